// ===== hw/pfc_pkg.sv
// Package for the PCM frame formatter configuration block.
// Holds register offsets, field positions, reset values, timing counts
// and the carrier structs. It is shared by the design and the bench.
package pfc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PFC_ADDR_FRAME_LEN = 8'hF0;
  localparam logic [7:0] PFC_ADDR_FORMAT = 8'hF1;
  localparam logic [7:0] PFC_RST_FRAME_LEN = 8'hFF;
  localparam logic [7:0] PFC_RST_FORMAT = 8'h01;
  localparam int PFC_BIT_RATE_SEL = 7;
  localparam int PFC_BIT_ENC = 6;
  localparam int PFC_BIT_COMP = 5;
  localparam int PFC_SLOT_MSB = 4;
  localparam logic [4:0] PFC_SLOTS_MIN = 5'h01;
  localparam logic [4:0] PFC_SLOTS_MAX = 5'h12;
  localparam int PFC_STROBE_PINS = 6;

  // ----------------------------------------------------------------
  // Timing: PCM clock period classification on the 25 MHz clock
  // ----------------------------------------------------------------
  localparam int PFC_SYS_CLK_KHZ = 25000;
  localparam int PFC_PCM_FAST_KHZ = 2048;
  localparam int PFC_PCM_SLOW_KHZ = 1536;
  // Threshold halfway between the two nominal periods in sys cycles.
  localparam int PFC_PERIOD_SPLIT = (PFC_SYS_CLK_KHZ / PFC_PCM_FAST_KHZ
                                    + PFC_SYS_CLK_KHZ / PFC_PCM_SLOW_KHZ
                                    + 1) / 2;
  localparam int PFC_FIFO_DEPTH = 4;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } pfc_reg_req_s;

  typedef struct packed {
    logic [5:0] chan;
    logic [4:0] slot;
  } pfc_slot_evt_s;

endpackage : pfc_pkg

// ===== hw/pfc_formatter.sv
// PCM frame formatter configuration block and its slot-event FIFO.
// Assumes the PCM clock pin is asynchronous to sys_clk and at least
// four times slower, and that software writes sane register values.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Slot-event FIFO
// ------------------------------------------------------------------
module pfc_fifo
  import pfc_pkg::*;
#(
  parameter int WIDTH = 11,
  parameter int DEPTH = 4
)
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } pfc_fifo_s;

  pfc_fifo_s st_ff;
  pfc_fifo_s nxt_st;
  logic push;
  logic pop;

  // Handshakes come straight from the fill count.
  assign in_ready = (st_ff.cnt != (AW + 1)'(DEPTH));
  assign out_valid = (st_ff.cnt != '0);
  assign out_data = st_ff.mem[st_ff.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer and count update; push and pop may share a cycle.
  always_comb
  begin
    nxt_st = st_ff;
    if (push)
    begin
      nxt_st.mem[st_ff.wp] = in_data;
      nxt_st.wp = (st_ff.wp == AW'(DEPTH - 1)) ? '0 : st_ff.wp + 1'b1;
    end
    if (pop)
    begin
      nxt_st.rp = (st_ff.rp == AW'(DEPTH - 1)) ? '0 : st_ff.rp + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  // State register.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end
endmodule : pfc_fifo

// ------------------------------------------------------------------
// Formatter top
// ------------------------------------------------------------------
module pfc_formatter
  import pfc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic pcm_clock_input,
  output logic [PFC_STROBE_PINS-1:0] frame_sync_strobe_outputs,
  output logic pcm_clock_rate_select,
  output logic rate_mismatch,
  output logic evt_overrun,
  output logic evt_valid,
  input wire logic evt_ready,
  output logic [5:0] evt_chan,
  output logic [4:0] evt_slot
);

  typedef struct packed {
    logic [1:0] ck_sync;
    logic ck_prev;
    logic [7:0] frame_bits_minus_one;
    logic [7:0] format;
    logic [7:0] bit_cnt;
    logic [5:0] strobe;
    logic [7:0] rdata;
    pfc_slot_evt_s pend_evt;
    logic pend;
    logic ovr;
    logic [4:0] per_cnt;
    logic rate_bad;
  } pfc_top_s;

  pfc_top_s st_ff;
  pfc_top_s nxt_st;
  pfc_reg_req_s req;
  pfc_slot_evt_s fifo_out;
  logic fifo_in_ready;
  logic rise;
  logic [4:0] used;
  logic [4:0] slot;
  logic [5:0] chan;
  logic chan_live;

  assign req = '{addr: reg_addr, wr: reg_wr, rd: reg_rd, wdata: reg_wdata};
  // Edge found on the second sync stage only.
  assign rise = st_ff.ck_sync[1] & ~st_ff.ck_prev;

  // Clamp the used slot count so a bad value cannot run past slot 18.
  always_comb
  begin
    used = st_ff.format[PFC_SLOT_MSB:0];
    if (used < PFC_SLOTS_MIN)
    begin
      used = PFC_SLOTS_MIN;
    end
    else if (used > PFC_SLOTS_MAX)
    begin
      used = PFC_SLOTS_MAX;
    end
  end

  // Channel carried in the current bit period.
  always_comb
  begin
    slot = st_ff.bit_cnt[7:3];
    chan_live = (slot < used);
    if (st_ff.format[PFC_BIT_COMP])
    begin
      chan = {slot, st_ff.bit_cnt[2]} + 6'h01;
    end
    else
    begin
      chan = {1'b0, slot} + 6'h01;
    end
    if (!chan_live)
    begin
      chan = 6'h00;
    end
  end

  // Next-state logic for the whole block.
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.ck_sync = {st_ff.ck_sync[0], pcm_clock_input};
    nxt_st.ck_prev = st_ff.ck_sync[1];
    // Register writes and registered read data.
    if (req.wr && req.addr == PFC_ADDR_FRAME_LEN)
    begin
      nxt_st.frame_bits_minus_one = req.wdata;
    end
    if (req.wr && req.addr == PFC_ADDR_FORMAT)
    begin
      nxt_st.format = req.wdata;
    end
    if (req.rd)
    begin
      case (req.addr)
        PFC_ADDR_FRAME_LEN: nxt_st.rdata = st_ff.frame_bits_minus_one;
        PFC_ADDR_FORMAT: nxt_st.rdata = st_ff.format;
        default: nxt_st.rdata = 8'h00;
      endcase
    end
    // Frame bit counter, one step per PCM clock rising edge.
    if (rise)
    begin
      if (st_ff.bit_cnt >= st_ff.frame_bits_minus_one)
      begin
        nxt_st.bit_cnt = 8'h00;
      end
      else
      begin
        nxt_st.bit_cnt = st_ff.bit_cnt + 8'h01;
      end
    end
    // Strobe pins: decoded one-hot for channels 1..6, else channel code.
    if (st_ff.format[PFC_BIT_ENC])
    begin
      nxt_st.strobe = chan;
    end
    else
    begin
      nxt_st.strobe = '0;
      for (int i = 0; i < PFC_STROBE_PINS; i++)
      begin
        nxt_st.strobe[i] = (chan == 6'(i + 1));
      end
    end
    // A format write clears the overrun flag; a loss in that same cycle
    // is assigned afterwards, so the set wins and no loss goes unseen.
    if (req.wr && req.addr == PFC_ADDR_FORMAT)
    begin
      nxt_st.ovr = 1'b0;
    end
    // One event per live channel start; held until the FIFO takes it.
    if (st_ff.pend && fifo_in_ready)
    begin
      nxt_st.pend = 1'b0;
    end
    if (rise && chan_live && st_ff.bit_cnt[1:0] == 2'b00
        && (st_ff.bit_cnt[2] == 1'b0 || st_ff.format[PFC_BIT_COMP]))
    begin
      if (st_ff.pend && !fifo_in_ready)
      begin
        nxt_st.ovr = 1'b1; // Old event kept; new one is lost.
      end
      else
      begin
        nxt_st.pend = 1'b1;
        nxt_st.pend_evt = '{chan: chan, slot: slot};
      end
    end
    // PCM clock period check against the selected rate.
    if (rise)
    begin
      nxt_st.per_cnt = 5'h00;
      nxt_st.rate_bad = ((int'(st_ff.per_cnt) >= PFC_PERIOD_SPLIT)
                         != st_ff.format[PFC_BIT_RATE_SEL]);
    end
    else if (st_ff.per_cnt != 5'h1F)
    begin
      nxt_st.per_cnt = st_ff.per_cnt + 5'h01;
    end
  end

  // State register; reset restores the defaults.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_ff <= '0;
      st_ff.frame_bits_minus_one <= PFC_RST_FRAME_LEN;
      st_ff.format <= PFC_RST_FORMAT;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Event FIFO drained by the serial data path.
  pfc_fifo #(
    .WIDTH($bits(pfc_slot_evt_s)),
    .DEPTH(PFC_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .srst(srst),
    .in_valid(st_ff.pend),
    .in_ready(fifo_in_ready),
    .in_data(st_ff.pend_evt),
    .out_valid(evt_valid),
    .out_ready(evt_ready),
    .out_data(fifo_out)
  );

  assign reg_rdata = st_ff.rdata;
  assign frame_sync_strobe_outputs = st_ff.strobe;
  assign pcm_clock_rate_select = st_ff.format[PFC_BIT_RATE_SEL];
  assign rate_mismatch = st_ff.rate_bad;
  assign evt_overrun = st_ff.ovr;
  assign evt_chan = fifo_out.chan;
  assign evt_slot = fifo_out.slot;

endmodule : pfc_formatter

// ===== test/pfc_codec_model.sv
// Far side model: PCM clock source and slot event consumer.
// Clock runs only while run is high; ready is the registered inverse of stall.
`timescale 1ns/1ps
module pfc_codec_model
(
  input wire logic sys_clk,
  input wire logic run,
  input wire logic stall,
  output logic pcm_clock_input,
  output logic evt_ready
);
  // A 320 ns clock, offset so its edges never meet sys_clk edges.
  initial
  begin
    pcm_clock_input = 1'b0;
    evt_ready = 1'b0;
    #7;
    forever
    begin
      #160;
      if (run)
        pcm_clock_input = ~pcm_clock_input;
    end
  end
  // Ready moves just after a rising edge, never on the sampling edge.
  always @(posedge sys_clk)
    evt_ready <= !stall;
endmodule : pfc_codec_model

// ===== test/pfc_formatter_asserts.sv
// Checker for the formatter's registers, strobes and event stream.
// Bound to pfc_formatter; sees its ports only.
`timescale 1ns/1ps
module pfc_formatter_asserts
  import pfc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  input logic [5:0] frame_sync_strobe_outputs,
  input logic pcm_clock_rate_select,
  input logic evt_overrun,
  input logic evt_valid,
  input wire logic evt_ready,
  input logic [5:0] evt_chan
);
  logic [7:0] len_ff;
  logic [7:0] fmt_ff;
  logic [4:0] n_c;
  logic [5:0] max_ch;
  // Shadows of the registers as software last wrote them.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      len_ff <= PFC_RST_FRAME_LEN;
      fmt_ff <= PFC_RST_FORMAT;
    end
    else if (reg_wr && reg_addr == PFC_ADDR_FRAME_LEN)
      len_ff <= reg_wdata;
    else if (reg_wr && reg_addr == PFC_ADDR_FORMAT)
      fmt_ff <= reg_wdata;
  end
  // Highest channel number the encoded strobes may carry.
  assign n_c = fmt_ff[4:0] > PFC_SLOTS_MAX ? PFC_SLOTS_MAX
             : (fmt_ff[4:0] == 5'h00 ? PFC_SLOTS_MIN : fmt_ff[4:0]);
  assign max_ch = fmt_ff[PFC_BIT_COMP] ? {n_c, 1'b0} : {1'b0, n_c};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_wr_fmt;
    reg_wr && reg_addr == PFC_ADDR_FORMAT;
  endsequence
  sequence s_rd(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  property p_rate;
    s_wr_fmt |=> pcm_clock_rate_select == $past(reg_wdata[7]);
  endproperty
  a_rate: assert property (p_rate) else $error("rate bit");
  property p_unmap;
    reg_rd && reg_addr != PFC_ADDR_FRAME_LEN
    && reg_addr != PFC_ADDR_FORMAT |=> reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_rdlen;
    s_rd(PFC_ADDR_FRAME_LEN) |=> reg_rdata == $past(len_ff);
  endproperty
  a_rdlen: assert property (p_rdlen) else $error("length read");
  property p_rdfmt;
    s_rd(PFC_ADDR_FORMAT) |=> reg_rdata == $past(fmt_ff);
  endproperty
  a_rdfmt: assert property (p_rdfmt) else $error("format read");
  // Strobes lag the format by a cycle, so a settled format is needed.
  property p_dec;
    !fmt_ff[PFC_BIT_ENC] && $stable(fmt_ff)
    |-> $onehot0(frame_sync_strobe_outputs);
  endproperty
  a_dec: assert property (p_dec) else $error("decoded strobes");
  property p_enc;
    fmt_ff[PFC_BIT_ENC] && $stable(fmt_ff)
    |-> frame_sync_strobe_outputs <= max_ch;
  endproperty
  a_enc: assert property (p_enc) else $error("encoded strobes");
  property p_hold;
    evt_valid && !evt_ready |=> evt_valid && $stable(evt_chan);
  endproperty
  a_hold: assert property (p_hold) else $error("event not held");
  // With the sink ready one cycle earlier the FIFO cannot be full, so
  // no loss can set the flag again in the clearing cycle.
  property p_ovr;
    s_wr_fmt ##0 $past(evt_ready) |=> !evt_overrun;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not cleared");
endmodule : pfc_formatter_asserts
bind pfc_formatter pfc_formatter_asserts u_chk (.sys_clk(sys_clk),
  .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .frame_sync_strobe_outputs(frame_sync_strobe_outputs),
  .pcm_clock_rate_select(pcm_clock_rate_select),
  .evt_overrun(evt_overrun), .evt_valid(evt_valid),
  .evt_ready(evt_ready), .evt_chan(evt_chan));

// ===== test/pfc_formatter_tb.sv
// Bench for pfc_formatter: registers, frame counts, rate check, FIFO.
// Relies on pfc_codec_model for the PCM clock and the event sink.
`timescale 1ns/1ps
module pfc_formatter_tb
  import pfc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic run = 1'b0;
  logic stall = 1'b0;
  logic [7:0] reg_rdata;
  logic pcm_clk, rsel, mism, ovr, evt_valid, evt_ready;
  logic [5:0] strb;
  logic [5:0] evt_chan;
  logic [4:0] evt_slot;
  int miscompares = 0;
  int n_compared = 0;
  int n_ev = 0;
  int cyc = 0;
  int n0;
  logic [5:0] ch0;
  // Software keeps 255 with rate bit 0 and 191 with rate bit 1.
  logic [7:0] lens [5] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hBF};
  logic [7:0] fmts [5] = '{8'h03, 8'h23, 8'h12, 8'h6A, 8'hA9};
  logic [7:0] evs [5] = '{8'h06, 8'h0C, 8'h24, 8'h28, 8'h24};
  pfc_formatter uut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .pcm_clock_input(pcm_clk),
    .frame_sync_strobe_outputs(strb), .pcm_clock_rate_select(rsel),
    .rate_mismatch(mism), .evt_overrun(ovr), .evt_valid(evt_valid),
    .evt_ready(evt_ready), .evt_chan(evt_chan), .evt_slot(evt_slot));
  pfc_codec_model u_codec (.sys_clk(sys_clk), .run(run), .stall(stall),
    .pcm_clock_input(pcm_clk), .evt_ready(evt_ready));
  initial
    forever #20 sys_clk = ~sys_clk;
  // Counts accepted events and cuts a hang short.
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (evt_valid === 1'b1 && evt_ready === 1'b1)
      n_ev <= n_ev + 1;
    if (cyc == 60000)
    begin
      miscompares = miscompares + 1;
      conclude();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, e);
  endtask : rd
  task automatic conclude();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  // Main sequence: reset values, each format, then a stalled FIFO.
  initial
  begin
    repeat (5) @(negedge sys_clk);
    srst = 1'b0;
    run = 1'b1;
    rd(PFC_ADDR_FRAME_LEN, PFC_RST_FRAME_LEN);
    rd(PFC_ADDR_FORMAT, PFC_RST_FORMAT);
    wr(8'h00, 8'h55);
    rd(8'h00, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      wr(PFC_ADDR_FRAME_LEN, lens[i]);
      wr(PFC_ADDR_FORMAT, fmts[i]);
      rd(PFC_ADDR_FORMAT, fmts[i]);
      repeat (2048) @(negedge sys_clk);
      n0 = n_ev;
      repeat (16 * (lens[i] + 1)) @(negedge sys_clk);
      chk(8'(n_ev - n0), evs[i]);
      // The 320 ns bench clock is faster than either rate: it reads as fast.
      chk({7'h00, mism}, {7'h00, fmts[i][7]});
      chk({7'h00, rsel}, {7'h00, fmts[i][7]});
      // Next event head: its channel must belong to its slot.
      for (int k = 0; k < 3000 && evt_valid !== 1'b1; k++)
        @(negedge sys_clk);
      ch0 = evt_chan - 6'h01;
      if (fmts[i][5])
        ch0 = ch0 >> 1;
      chk({2'b00, ch0}, {3'h0, evt_slot});
      chk({7'h00, evt_slot < fmts[i][4:0]}, 8'h01);
    end
    stall = 1'b1;
    wr(PFC_ADDR_FRAME_LEN, 8'hFF);
    wr(PFC_ADDR_FORMAT, 8'h23);
    repeat (4096) @(negedge sys_clk);
    chk({7'h00, ovr}, 8'h01);
    // Sink ready again before the clearing write, so nothing is lost then.
    stall = 1'b0;
    repeat (2) @(negedge sys_clk);
    wr(PFC_ADDR_FORMAT, 8'h23);
    chk({7'h00, ovr}, 8'h00);
    for (int k = 0; k < 200 && evt_valid !== 1'b0; k++)
      @(negedge sys_clk);
    chk({7'h00, evt_valid}, 8'h00);
    conclude();
  end
endmodule : pfc_formatter_tb
